/* isq_responder.v */
// Input status query responder: decodes read commands and sends the status word as hex text.
//
// The register offsets and the strobed register port were left to the implementer.
`default_nettype none
`include "isq_regs.vh"

// ==========================================================
// How it works
// R1 - Reply word sent as hexadecimal characters.
// R2 - Device query returns 32-bit word, 1 means on.
// R3 - Bits 0-6 servo, limits, torque, proportional, reset.
// R4 - Bits 11,12,16,17,18 start, stop, mode, dog.
// R5 - Bits 19-26 point select, override, stop, handwheel.
// R6 - Unassigned device bits return zero.
// R7 - Master sends 12h with 40h for pins.
// R8 - Pin reply carries bits 0 to 9.
// R9 - Master sends 12h with 60h for comm devices.
// R10 - Comm reply uses same device bit layout.
// R11 - Master sends 12h with 00h for devices.

module isq_responder #(
	parameter PIN_W = 10
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_q,
	// Input devices
	input wire servo_enable_in,
	input wire fwd_stroke_limit,
	input wire rev_stroke_limit,
	input wire ext_torque_limit_sel,
	input wire int_torque_limit_sel,
	input wire proportional_ctrl_sel,
	input wire alarm_reset_in,
	input wire fwd_start,
	input wire rev_start,
	input wire forced_stop,
	input wire auto_manual_sel,
	input wire prox_dog_in,
	input wire point_sel_1,
	input wire point_sel_2,
	input wire point_sel_3,
	input wire point_sel_4,
	input wire override_sel,
	input wire temp_stop_restart,
	input wire handwheel_mult_1,
	input wire handwheel_mult_2,
	// Raw external input pins
	input wire [PIN_W-1:0] ext_pin_in,
	// Reply character stream
	output reg [7:0] reply_char_q,
	output reg reply_valid_q,
	output reg reply_last_q
);

	// ==========================================================
	// States
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_SEND = 2'b10;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [31:0] word_q;
	reg [31:0] word_d;
	reg [31:0] comm_on_q;
	reg [2:0] idx_q;
	reg [2:0] idx_d;
	reg bad_q;
	reg refused_q;

	wire [31:0] pin_dev_w;
	wire [31:0] logic_dev_w;
	wire [31:0] raw_pin_w;
	wire [63:0] hex_w;
	wire [2:0] sel_w;
	wire cmd_wr;
	wire stat_wr;
	wire busy;
	wire code_ok_w;
	wire cmd_take;
	wire last_w;
	reg cmd_ok;

	// ==========================================================
	// Device word assembly
	assign pin_dev_w[`ISQ_B_SERVO_EN] = servo_enable_in; // R3
	assign pin_dev_w[`ISQ_B_FWD_LIM] = fwd_stroke_limit; // R3
	assign pin_dev_w[`ISQ_B_REV_LIM] = rev_stroke_limit; // R3
	assign pin_dev_w[`ISQ_B_EXT_TL] = ext_torque_limit_sel; // R3
	assign pin_dev_w[`ISQ_B_INT_TL] = int_torque_limit_sel; // R3
	assign pin_dev_w[`ISQ_B_PROP] = proportional_ctrl_sel; // R3
	assign pin_dev_w[`ISQ_B_ALM_RST] = alarm_reset_in; // R3
	assign pin_dev_w[`ISQ_B_FWD_START-1:`ISQ_B_ALM_RST+1] = 4'h0; // R6
	assign pin_dev_w[`ISQ_B_FWD_START] = fwd_start; // R4
	assign pin_dev_w[`ISQ_B_REV_START] = rev_start; // R4
	assign pin_dev_w[`ISQ_B_FORCED_STOP-1:`ISQ_B_REV_START+1] = 3'h0; // R6
	assign pin_dev_w[`ISQ_B_FORCED_STOP] = forced_stop; // R4
	assign pin_dev_w[`ISQ_B_AUTO_MAN] = auto_manual_sel; // R4
	assign pin_dev_w[`ISQ_B_PROX_DOG] = prox_dog_in; // R4
	assign pin_dev_w[`ISQ_B_POINT_1] = point_sel_1; // R5
	assign pin_dev_w[`ISQ_B_POINT_2] = point_sel_2; // R5
	assign pin_dev_w[`ISQ_B_POINT_3] = point_sel_3; // R5
	assign pin_dev_w[`ISQ_B_POINT_4] = point_sel_4; // R5
	assign pin_dev_w[`ISQ_B_OVERRIDE] = override_sel; // R5
	assign pin_dev_w[`ISQ_B_TEMP_STOP] = temp_stop_restart; // R5
	assign pin_dev_w[`ISQ_B_HW_MULT_1] = handwheel_mult_1; // R5
	assign pin_dev_w[`ISQ_B_HW_MULT_2] = handwheel_mult_2; // R5
	assign pin_dev_w[31:`ISQ_B_HW_MULT_2+1] = 5'h00; // R6

	// A device counts as on if its pin or the link switches it on.
	assign logic_dev_w = pin_dev_w | comm_on_q; // R2
	assign raw_pin_w = {{(32-PIN_W){1'b0}}, ext_pin_in}; // R8

	// ==========================================================
	// Hex character conversion, one entry per nibble
	genvar g;
	generate
		for (g = 0; g < `ISQ_NIBBLES; g = g + 1) begin : g_hex
			wire [3:0] nib;
			assign nib = word_q[4*g +: 4];
			assign hex_w[8*g +: 8] = (nib < `ISQ_NIB_TEN) ?
				(`ISQ_ASCII_0 + {4'h0, nib}) : (`ISQ_ASCII_A_OFS + {4'h0, nib}); // R1
		end
	endgenerate

	// Most significant nibble goes out first.
	assign sel_w = `ISQ_LAST_IDX - idx_q; // R1

	// ==========================================================
	// Command decode
	assign cmd_wr = reg_wr && (reg_addr == `ISQ_OFS_CMD);
	assign stat_wr = reg_wr && (reg_addr == `ISQ_OFS_STAT);
	assign busy = state_q[1];
	assign code_ok_w = (reg_wdata[`ISQ_CMD_CODE] == `ISQ_CMD_READ);
	assign cmd_take = state_q[0] && cmd_wr && cmd_ok;
	assign last_w = (idx_q == `ISQ_LAST_IDX);

	always @* begin
		cmd_ok = 1'b0;
		word_d = word_q;
		if (code_ok_w) begin
			case (reg_wdata[`ISQ_CMD_DN])
				`ISQ_DN_DEV: begin
					cmd_ok = 1'b1;
					word_d = logic_dev_w; // R11
				end
				`ISQ_DN_PIN: begin
					cmd_ok = 1'b1;
					word_d = raw_pin_w; // R7
				end
				`ISQ_DN_COMM: begin
					cmd_ok = 1'b1;
					word_d = comm_on_q; // R9
				end
				default: begin
					cmd_ok = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Sequencer
	always @* begin
		state_d = state_q;
		idx_d = idx_q;
		case (state_q)
			ST_IDLE: begin
				if (cmd_wr && cmd_ok) begin
					state_d = ST_SEND;
					idx_d = 3'h0;
				end
			end
			ST_SEND: begin
				idx_d = idx_q + 3'h1;
				if (last_w) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
				idx_d = 3'h0;
			end
		endcase
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			idx_q <= 3'h0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
		end
	end

	// ==========================================================
	// Reply word snapshot
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			word_q <= 32'h0000_0000;
		end else begin
			// The word is frozen for the whole reply so the text stays consistent.
			if (cmd_take) begin
				word_q <= word_d; // R2
			end
		end
	end

	// ==========================================================
	// Reply character output
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			reply_char_q <= 8'h00;
			reply_valid_q <= 1'b0;
			reply_last_q <= 1'b0;
		end else begin
			reply_valid_q <= busy;
			reply_char_q <= busy ? hex_w[8*sel_w +: 8] : 8'h00; // R1
			reply_last_q <= busy && last_w;
		end
	end

	// ==========================================================
	// Devices switched on through the link
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			comm_on_q <= 32'h0000_0000;
		end else begin
			if (reg_wr && (reg_addr == `ISQ_OFS_COMM)) begin
				// Bits with no device are dropped, so they always read zero.
				comm_on_q <= reg_wdata & `ISQ_DEV_MASK; // R10
			end
		end
	end

	// ==========================================================
	// Sticky error flags
	// A new error in the clearing cycle wins over the clear.
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			bad_q <= 1'b0;
		end else begin
			if (cmd_wr && state_q[0] && !cmd_ok) begin
				bad_q <= 1'b1;
			end else if (stat_wr && reg_wdata[`ISQ_ST_BAD]) begin
				bad_q <= 1'b0;
			end
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			refused_q <= 1'b0;
		end else begin
			if (cmd_wr && busy) begin
				refused_q <= 1'b1;
			end else if (stat_wr && reg_wdata[`ISQ_ST_REFUSED]) begin
				refused_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Register read port
	// Read data stand for one cycle only and are zero otherwise.
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			reg_rdata_q <= 32'h0000_0000;
		end else begin
			reg_rdata_q <= 32'h0000_0000;
			if (reg_rd) begin
				case (reg_addr)
					// The command register is write-only.
					`ISQ_OFS_CMD: begin
						reg_rdata_q <= 32'h0000_0000;
					end
					`ISQ_OFS_COMM: begin
						reg_rdata_q <= comm_on_q;
					end
					`ISQ_OFS_WORD: begin
						reg_rdata_q <= word_q;
					end
					`ISQ_OFS_STAT: begin
						reg_rdata_q[`ISQ_ST_BUSY] <= busy;
						reg_rdata_q[`ISQ_ST_BAD] <= bad_q;
						reg_rdata_q[`ISQ_ST_REFUSED] <= refused_q;
					end
					default: begin
						reg_rdata_q <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

endmodule // isq_responder

`default_nettype wire

/* isq_regs.vh */
// Register offsets, command codes and field positions of the status query responder.
`ifndef ISQ_REGS_VH
`define ISQ_REGS_VH

// ==========================================================
// Register byte offsets
`define ISQ_OFS_CMD 8'h00
`define ISQ_OFS_COMM 8'h04
`define ISQ_OFS_WORD 8'h08
`define ISQ_OFS_STAT 8'h0C

// ==========================================================
// Command code and data numbers
`define ISQ_CMD_READ 8'h12
`define ISQ_DN_DEV 8'h00
`define ISQ_DN_PIN 8'h40
`define ISQ_DN_COMM 8'h60

// ==========================================================
// Command register fields
`define ISQ_CMD_CODE 15:8
`define ISQ_CMD_DN 7:0

// ==========================================================
// Status register bits
`define ISQ_ST_BUSY 0
`define ISQ_ST_BAD 1
`define ISQ_ST_REFUSED 2

// ==========================================================
// Input device bit positions in the status word
`define ISQ_B_SERVO_EN 0
`define ISQ_B_FWD_LIM 1
`define ISQ_B_REV_LIM 2
`define ISQ_B_EXT_TL 3
`define ISQ_B_INT_TL 4
`define ISQ_B_PROP 5
`define ISQ_B_ALM_RST 6
`define ISQ_B_FWD_START 11
`define ISQ_B_REV_START 12
`define ISQ_B_FORCED_STOP 16
`define ISQ_B_AUTO_MAN 17
`define ISQ_B_PROX_DOG 18
`define ISQ_B_POINT_1 19
`define ISQ_B_POINT_2 20
`define ISQ_B_POINT_3 21
`define ISQ_B_POINT_4 22
`define ISQ_B_OVERRIDE 23
`define ISQ_B_TEMP_STOP 24
`define ISQ_B_HW_MULT_1 25
`define ISQ_B_HW_MULT_2 26

// Bits that carry a device; all others read as zero.
`define ISQ_DEV_MASK 32'h07FF187F

// ==========================================================
// Reply character encoding
`define ISQ_NIBBLES 8
`define ISQ_LAST_IDX 3'h7
`define ISQ_ASCII_0 8'h30
`define ISQ_ASCII_A_OFS 8'h37
`define ISQ_NIB_TEN 4'hA

`endif

/* isq_props.sv */
// Assertion checker for the status query responder.
`default_nettype none
module isq_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata_q,
	// Reply stream
	input wire logic [7:0] reply_char_q,
	input wire logic reply_valid_q,
	input wire logic reply_last_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	logic acc;
	wire [7:0] dn = reg_wdata[7:0];
	// Mirrors the busy window, so a refused command is not taken for an accepted one.
	assign acc = reg_wr && reg_addr == 8'h00 && reg_wdata[15:8] == 8'h12 && cnt_q == 4'h0
		&& (dn == 8'h00 || dn == 8'h40 || dn == 8'h60);
	always_ff @(posedge clk_sys) begin
		if (!rst_n) cnt_q <= 4'h0;
		else if (acc) cnt_q <= 4'h8;
		else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	run_len_a: assert property ($rose(reply_valid_q) |-> reply_valid_q[*8] ##1 !reply_valid_q)
		else $error("reply run length wrong");
	last_pos_a: assert property ($rose(reply_valid_q) |-> ##7 reply_last_q)
		else $error("last flag misplaced");
	last_end_a: assert property (reply_last_q |-> reply_valid_q ##1 !reply_valid_q)
		else $error("last flag not at end");
	hex_char_a: assert property (reply_valid_q |->
		reply_char_q inside {[8'h30:8'h39], [8'h41:8'h46]}) else $error("not a hex character");
	reply_start_a: assert property (acc |-> ##2 $rose(reply_valid_q))
		else $error("reply did not start");
	no_reply_a: assert property (cnt_q == 4'h0 && !acc |-> ##2 !reply_valid_q)
		else $error("reply without command");
	pin_top_a: assert property (acc && dn == 8'h40 |-> ##2 (reply_char_q == 8'h30)[*5])
		else $error("pin reply upper bits set");
	dev_top_a: assert property (acc && dn != 8'h40 |->
		##2 reply_char_q == 8'h30 ##1 reply_char_q < 8'h38) else $error("spare bits set");
	idle_char_a: assert property (!reply_valid_q |-> reply_char_q == 8'h00)
		else $error("character outside reply");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
		else $error("read data outside read cycle");
	cover property (acc && dn == 8'h00);
	cover property (reg_wr && reg_addr == 8'h00 && cnt_q != 4'h0);
	cover property (reply_last_q ##2 reply_valid_q);
	cover property (reg_rd ##1 reg_rdata_q != 32'h0);
endmodule // isq_props
bind isq_responder isq_props u_isq_props (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.reply_char_q(reply_char_q), .reply_valid_q(reply_valid_q), .reply_last_q(reply_last_q));
`default_nettype wire

/* isq_master_model.sv */
// Master station model that turns reply characters back into a status word.
`default_nettype none
module isq_master_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Reply stream
	input wire logic [7:0] reply_char_q,
	input wire logic reply_valid_q,
	input wire logic reply_last_q,
	// Decoded word
	output logic [31:0] word_q,
	output logic done_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] nib;
	// Letters sit seven codes above the digits, so letters subtract 37h and digits subtract 30h.
	assign nib = reply_char_q - (reply_char_q > 8'h39 ? 8'h37 : 8'h30);
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			word_q <= 32'h0;
			done_q <= 1'b0;
		end else begin
			if (reply_valid_q) word_q <= {word_q[27:0], nib[3:0]};
			done_q <= reply_valid_q && reply_last_q;
		end
	end
endmodule // isq_master_model
`default_nettype wire

/* input_status_query_responder_test.sv */
// Self-checking bench for the input status query responder.
`default_nettype none
module input_status_query_responder_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] MASK = 32'h07FF187F;
	logic clk_sys, rst_n, reg_wr, reg_rd, vld, lst, md;
	logic [7:0] reg_addr, ch;
	logic [31:0] reg_wdata, rdata, dv, comm, mw, e;
	logic [9:0] pins;
	logic [31:0] q[$];
	int bad_count, tests_run, seed, i;
	isq_responder #(.PIN_W(10)) u_isq_responder (.clk_sys(clk_sys), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_q(rdata), .ext_pin_in(pins), .reply_char_q(ch), .reply_valid_q(vld),
		.reply_last_q(lst), .servo_enable_in(dv[0]), .fwd_stroke_limit(dv[1]),
		.rev_stroke_limit(dv[2]), .ext_torque_limit_sel(dv[3]), .int_torque_limit_sel(dv[4]),
		.proportional_ctrl_sel(dv[5]), .alarm_reset_in(dv[6]), .fwd_start(dv[11]),
		.rev_start(dv[12]), .forced_stop(dv[16]), .auto_manual_sel(dv[17]), .prox_dog_in(dv[18]),
		.point_sel_1(dv[19]), .point_sel_2(dv[20]), .point_sel_3(dv[21]),
		.point_sel_4(dv[22]), .override_sel(dv[23]), .temp_stop_restart(dv[24]),
		.handwheel_mult_1(dv[25]), .handwheel_mult_2(dv[26]));
	isq_master_model u_isq_master_model (.clk_sys(clk_sys), .rst_n(rst_n), .reply_char_q(ch),
		.reply_valid_q(vld), .reply_last_q(lst), .word_q(mw), .done_q(md));
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task chk(input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task give_verdict;
		if (bad_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(rdata, x);
		@(posedge clk_sys);
	endtask
	task cmd(input logic [7:0] dn);
		case (dn)
			8'h00: e = (dv | comm) & MASK;
			8'h40: e = {22'h0, pins};
			default: e = comm & MASK;
		endcase
		q.push_back(e);
		wr(8'h00, {16'h0012, dn} << 0);
	endtask
	task drain;
		for (i = 0; i < 40 && q.size() != 0; i++) @(posedge clk_sys);
		if (q.size() != 0) begin
			bad_count++;
			give_verdict;
		end
	endtask
	// Every decoded reply is matched against the oldest expectation.
	always @(posedge clk_sys) if (md === 1'b1) chk(mw, q.size() ? q.pop_front() : 'x);
	initial begin
		rst_n = 1'b0;
		{reg_wr, reg_rd, reg_addr, reg_wdata, dv, pins, comm} = '0;
		seed = 57342;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(8'h0C, 32'h0);
		for (int k = 0; k < 6; k++) begin
			dv <= $random(seed);
			pins <= 10'($random(seed));
			comm = $random(seed);
			wr(8'h04, comm);
			rd(8'h04, comm & MASK);
			cmd(8'h20 * (k % 3) + (k % 3 != 0 ? 8'h20 : 8'h0));
			drain;
			rd(8'h08, e);
		end
		// A command in the busy window is refused; the one at busy release is taken.
		cmd(8'h40);
		wr(8'h00, 32'h1200);
		rd(8'h0C, 32'h5);
		repeat (3) @(posedge clk_sys);
		cmd(8'h60);
		drain;
		wr(8'h00, 32'h1255);
		repeat (12) @(posedge clk_sys);
		rd(8'h0C, 32'h6);
		wr(8'h0C, 32'h7);
		rd(8'h0C, 32'h0);
		rd(8'h20, 32'h0);
		repeat (2) @(posedge clk_sys);
		give_verdict;
	end
endmodule // input_status_query_responder_test
`default_nettype wire
